// >>> common/cfgm_consts.vh
// Token codes, address patterns, request kinds and field lengths for the config message handler
`ifndef CFGM_CONSTS_VH
`define CFGM_CONSTS_VH

// ----------------------------------------------------------------------------
// Control token values
// ----------------------------------------------------------------------------
`define CFGM_TOK_END 8'h01
`define CFGM_TOK_OK 8'h03
`define CFGM_TOK_FAIL 8'h04
`define CFGM_TOK_NODE_WR 8'hC0
`define CFGM_TOK_NODE_RD 8'hC1
`define CFGM_TOK_PER_WR 8'h24
`define CFGM_TOK_PER_RD 8'h25

// ----------------------------------------------------------------------------
// Destination patterns of the request channel
// ----------------------------------------------------------------------------
`define CFGM_NODE_LOW16 16'hC30C
`define CFGM_PER_LOW8 8'h02

// ----------------------------------------------------------------------------
// Request kinds
// ----------------------------------------------------------------------------
`define CFGM_KIND_NWR 2'h0
`define CFGM_KIND_NRD 2'h1
`define CFGM_KIND_PWR 2'h2
`define CFGM_KIND_PRD 2'h3

// ----------------------------------------------------------------------------
// Field lengths in bytes, minus one
// ----------------------------------------------------------------------------
`define CFGM_RESP_LAST 8'h02
`define CFGM_NREG_LAST 8'h01
`define CFGM_WORD_LAST 8'h03

`endif

// >>> hw/cfgm_bshift.v
// Byte-wide shift register that gathers or emits a multi-byte field
`timescale 1ns/1ps

module cfgm_bshift #(
    parameter NB = 4 // Field width in bytes
) (
    input wire clk_i,
    input wire resetn_i,
    input wire shift_i, // Shift in one byte at the low end
    input wire load_i, // Parallel load, wins over shift
    input wire [8*NB-1:0] load_val_i,
    input wire [7:0] byte_i,
    output wire [8*NB-1:0] val_o, // Whole field
    output wire [7:0] top_o // Most significant byte, next to send
);

    reg [8*NB-1:0] val_q; // Field storage

    // ------------------------------------------------------------------------
    // Storage, first byte ends up most significant
    // ------------------------------------------------------------------------
    always @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            val_q <= {(8*NB){1'b0}};
        end
        else if (load_i)
        begin
            val_q <= load_val_i;
        end
        else if (shift_i)
        begin
            val_q <= {val_q[8*NB-9:0], byte_i};
        end
    end

    assign val_o = val_q;
    assign top_o = val_q[8*NB-1:8*NB-8];

endmodule

// >>> hw/cfgm_msg.v
// Request interpreter for node and peripheral configuration register messages
`timescale 1ns/1ps
`include "cfgm_consts.vh"
//
// Overview of operation
// R1 - Node target: destination low half C30C
// R2 - Peripheral target: destination node, peripheral, 02
// R3 - Node write: 192, resp, reg16, data32, end
// R4 - Node read: 193, resp, reg16, end
// R5 - Write reply: 3,1 success; 4,1 failure
// R6 - Node read reply: 3, word, 1; else 4,1
// R7 - Peripheral write: 36, resp, reg, size, bytes, end
// R8 - Peripheral read: 37 ...; reply 3, data, 1
// R9 - Reply goes to carried response channel-end
// R10 - Unknown or malformed request answers 4,1

module cfgm_msg (
    input wire clk_i,
    input wire resetn_i,
    // Incoming token stream
    input wire tok_valid_i,
    input wire tok_ctrl_i,
    input wire [7:0] tok_data_i,
    input wire [31:0] req_dest_i,
    output wire tok_ready_o,
    // Outgoing reply tokens
    output wire out_valid_o,
    output wire out_ctrl_o,
    output wire [7:0] out_data_o,
    output wire [23:0] out_dest_o,
    input wire out_ready_i,
    // Node configuration register port
    output wire cfg_req_o,
    output wire cfg_we_o,
    output wire [15:0] cfg_addr_o,
    output wire [31:0] cfg_wdata_o,
    input wire cfg_ack_i,
    input wire cfg_ok_i,
    input wire [31:0] cfg_rdata_i,
    // Analogue peripheral register port, one byte per access
    output wire per_req_o,
    output wire per_we_o,
    output wire [7:0] per_id_o,
    output wire [7:0] per_addr_o,
    output wire [7:0] per_wdata_o,
    input wire per_ack_i,
    input wire per_ok_i,
    input wire [7:0] per_rdata_i
);

    // ------------------------------------------------------------------------
    // State codes
    // ------------------------------------------------------------------------
    localparam [3:0] S_IDLE = 4'h0; // Waiting for a header token
    localparam [3:0] S_RESP = 4'h1; // Response channel-end bytes
    localparam [3:0] S_REG = 4'h2; // Register number bytes
    localparam [3:0] S_SIZE = 4'h3; // Peripheral size byte
    localparam [3:0] S_WDAT = 4'h4; // Write data bytes
    localparam [3:0] S_PWAIT = 4'h5; // Peripheral byte write in flight
    localparam [3:0] S_END = 4'h6; // Expecting the closing token
    localparam [3:0] S_DRAIN = 4'h7; // Discarding a bad request
    localparam [3:0] S_NACC = 4'h8; // Node access in flight
    localparam [3:0] S_PRD = 4'h9; // Peripheral byte read in flight
    localparam [3:0] S_TXOK = 4'hA; // Send success token
    localparam [3:0] S_TXW = 4'hB; // Send node read word
    localparam [3:0] S_TXB = 4'hC; // Send one peripheral byte
    localparam [3:0] S_TXEND = 4'hD; // Send closing token
    localparam [3:0] S_TXFAIL = 4'hE; // Send failure token

    reg [3:0] state_q; // Main state
    reg [1:0] kind_q; // Request kind
    reg bad_q; // Request already doomed to fail
    reg [7:0] cnt_q; // Byte counter within a field
    reg [7:0] size_q; // Peripheral transfer size
    reg [7:0] preg_q; // Peripheral register pointer
    reg [7:0] pid_q; // Peripheral identifier
    reg [7:0] pbyte_q; // Peripheral read byte awaiting send
    reg o_valid_q; // Reply token pending
    reg o_ctrl_q; // Reply token is a control token
    reg [7:0] o_data_q; // Reply token value
    reg cfg_req_q; // Node access strobe
    reg cfg_we_q; // Node access is a write
    reg per_req_q; // Peripheral access strobe
    reg per_we_q; // Peripheral access is a write
    reg [7:0] per_wdata_q; // Peripheral write byte

    wire [23:0] resp_val; // Collected response channel-end
    wire [15:0] reg_val; // Collected node register number
    wire [31:0] word_val; // Node write data or read result
    wire [7:0] word_top; // Next read byte to send

    // ------------------------------------------------------------------------
    // Input and output handshakes
    // ------------------------------------------------------------------------
    // Input stalls while an access or a reply is under way
    assign tok_ready_o = (state_q <= S_WDAT) || (state_q == S_END) || (state_q == S_DRAIN);
    wire acc = tok_valid_i && tok_ready_o; // Token taken this cycle
    wire dat = acc && !tok_ctrl_i; // Data byte taken
    wire is_end = tok_ctrl_i && (tok_data_i == `CFGM_TOK_END);
    wire tx_free = !o_valid_q || out_ready_i; // Room for a new reply token
    wire [7:0] cnt_inc = cnt_q + 8'h01;
    wire node = (kind_q == `CFGM_KIND_NWR) || (kind_q == `CFGM_KIND_NRD);
    // Header decode; kind code is the peripheral flag over header bit 0
    wire hdr_node = tok_ctrl_i
        && ((tok_data_i == `CFGM_TOK_NODE_WR) || (tok_data_i == `CFGM_TOK_NODE_RD));
    wire hdr_per = tok_ctrl_i
        && ((tok_data_i == `CFGM_TOK_PER_WR) || (tok_data_i == `CFGM_TOK_PER_RD));
    wire [1:0] hdr_kind = {hdr_per, tok_data_i[0]};
    wire abort = acc && ((state_q == S_IDLE) ? !(hdr_node || hdr_per)
        : (tok_ctrl_i && (state_q != S_END) && (state_q != S_DRAIN)));

    // ------------------------------------------------------------------------
    // Field collectors
    // ------------------------------------------------------------------------
    cfgm_bshift #(.NB(3)) u_resp (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .shift_i(dat && (state_q == S_RESP)),
        .load_i(1'b0),
        .load_val_i(24'h00_0000),
        .byte_i(tok_data_i),
        .val_o(resp_val),
        .top_o()
    );

    cfgm_bshift #(.NB(2)) u_reg (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .shift_i(dat && (state_q == S_REG) && node),
        .load_i(1'b0),
        .load_val_i(16'h0000),
        .byte_i(tok_data_i),
        .val_o(reg_val),
        .top_o()
    );

    // Shared by write data and read result; only one is live per request
    cfgm_bshift #(.NB(4)) u_word (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .shift_i((dat && (state_q == S_WDAT) && node) || ((state_q == S_TXW) && tx_free)),
        .load_i((state_q == S_NACC) && cfg_ack_i && cfg_ok_i && !cfg_we_q),
        .load_val_i(cfg_rdata_i),
        .byte_i(tok_data_i),
        .val_o(word_val),
        .top_o(word_top)
    );

    // ------------------------------------------------------------------------
    // Request parser, access sequencer and reply generator
    // ------------------------------------------------------------------------
    always @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            state_q <= S_IDLE;
            kind_q <= `CFGM_KIND_NWR;
            bad_q <= 1'b0;
            cnt_q <= 8'h00;
            size_q <= 8'h00;
            preg_q <= 8'h00;
            pid_q <= 8'h00;
            pbyte_q <= 8'h00;
            o_valid_q <= 1'b0;
            o_ctrl_q <= 1'b0;
            o_data_q <= 8'h00;
            cfg_req_q <= 1'b0;
            cfg_we_q <= 1'b0;
            per_req_q <= 1'b0;
            per_we_q <= 1'b0;
            per_wdata_q <= 8'h00;
        end
        else
        begin
            // Strobes last one cycle; pending token drops once taken
            cfg_req_q <= 1'b0;
            per_req_q <= 1'b0;
            if (o_valid_q && out_ready_i)
            begin
                o_valid_q <= 1'b0;
            end
            // Bad header or control token inside a field aborts it
            if (abort)
            begin
                bad_q <= 1'b1; // see R10
                state_q <= is_end ? S_TXFAIL : S_DRAIN; // see R10
            end
            else
            begin
                case (state_q)
                    S_IDLE:
                    begin
                        cnt_q <= 8'h00;
                        pid_q <= req_dest_i[15:8]; // see R2
                        if (acc)
                        begin
                            kind_q <= hdr_kind; // see R3, R4, R7, R8
                            bad_q <= hdr_node ? (req_dest_i[15:0] != `CFGM_NODE_LOW16) // see R1
                                : (req_dest_i[7:0] != `CFGM_PER_LOW8); // see R2
                            state_q <= S_RESP;
                        end
                    end
                    S_RESP:
                    begin
                        if (dat)
                        begin
                            cnt_q <= (cnt_q == `CFGM_RESP_LAST) ? 8'h00 : cnt_inc;
                            state_q <= (cnt_q == `CFGM_RESP_LAST) ? S_REG : S_RESP;
                        end
                    end
                    S_REG:
                    begin
                        if (dat && !node)
                        begin
                            preg_q <= tok_data_i; // see R7
                            state_q <= S_SIZE;
                        end
                        else if (dat)
                        begin
                            cnt_q <= (cnt_q == `CFGM_NREG_LAST) ? 8'h00 : cnt_inc;
                            if (cnt_q == `CFGM_NREG_LAST)
                            begin
                                state_q <= (kind_q == `CFGM_KIND_NWR) ? S_WDAT : S_END; // see R3
                            end
                        end
                    end
                    S_SIZE:
                    begin
                        if (dat)
                        begin
                            size_q <= tok_data_i; // see R8
                            cnt_q <= 8'h00;
                            state_q <= ((kind_q == `CFGM_KIND_PWR) && (tok_data_i != 8'h00))
                                       ? S_WDAT : S_END; // see R7
                        end
                    end
                    S_WDAT:
                    begin
                        if (dat && node)
                        begin
                            cnt_q <= cnt_inc;
                            state_q <= (cnt_q == `CFGM_WORD_LAST) ? S_END : S_WDAT; // see R3
                        end
                        else if (dat)
                        begin
                            // Byte written straight through, no staging buffer
                            per_wdata_q <= tok_data_i;
                            per_we_q <= 1'b1;
                            per_req_q <= !bad_q;
                            state_q <= S_PWAIT; // see R7
                        end
                    end
                    S_PWAIT:
                    begin
                        if (per_ack_i || bad_q)
                        begin
                            bad_q <= bad_q || !per_ok_i; // see R5
                            preg_q <= preg_q + 8'h01;
                            cnt_q <= cnt_inc;
                            state_q <= (cnt_inc == size_q) ? S_END : S_WDAT;
                        end
                    end
                    S_END:
                    begin
                        if (acc && is_end && bad_q)
                        begin
                            state_q <= S_TXFAIL; // see R10
                        end
                        else if (acc && is_end && node)
                        begin
                            cfg_req_q <= 1'b1;
                            cfg_we_q <= (kind_q == `CFGM_KIND_NWR);
                            state_q <= S_NACC;
                        end
                        else if (acc && is_end)
                        begin
                            cnt_q <= 8'h00;
                            per_we_q <= 1'b0;
                            per_req_q <= (kind_q == `CFGM_KIND_PRD) && (size_q != 8'h00);
                            state_q <= ((kind_q == `CFGM_KIND_PRD) && (size_q != 8'h00))
                                       ? S_PRD : S_TXOK; // see R5
                        end
                        else if (acc)
                        begin
                            // Surplus data or wrong token before the end
                            bad_q <= 1'b1; // see R10
                            state_q <= S_DRAIN;
                        end
                    end
                    S_DRAIN:
                    begin
                        if (acc && is_end)
                        begin
                            state_q <= S_TXFAIL; // see R10
                        end
                    end
                    S_NACC:
                    begin
                        if (cfg_ack_i)
                        begin
                            cnt_q <= 8'h00;
                            state_q <= cfg_ok_i ? S_TXOK : S_TXFAIL; // see R6
                        end
                    end
                    S_PRD:
                    begin
                        if (per_ack_i)
                        begin
                            // Late failures cannot retract the success token sent
                            pbyte_q <= per_ok_i ? per_rdata_i : 8'h00;
                            preg_q <= preg_q + 8'h01;
                            if (cnt_q == 8'h00)
                            begin
                                state_q <= per_ok_i ? S_TXOK : S_TXFAIL; // see R8
                            end
                            else
                            begin
                                state_q <= S_TXB;
                            end
                        end
                    end
                    S_TXOK:
                    begin
                        if (tx_free)
                        begin
                            o_valid_q <= 1'b1;
                            o_ctrl_q <= 1'b1;
                            o_data_q <= `CFGM_TOK_OK; // see R5
                            if (kind_q == `CFGM_KIND_NRD)
                            begin
                                state_q <= S_TXW; // see R6
                            end
                            else if ((kind_q == `CFGM_KIND_PRD) && (size_q != 8'h00))
                            begin
                                state_q <= S_TXB; // see R8
                            end
                            else
                            begin
                                state_q <= S_TXEND;
                            end
                        end
                    end
                    S_TXW:
                    begin
                        if (tx_free)
                        begin
                            o_valid_q <= 1'b1;
                            o_ctrl_q <= 1'b0;
                            o_data_q <= word_top; // see R6
                            cnt_q <= cnt_inc;
                            state_q <= (cnt_q == `CFGM_WORD_LAST) ? S_TXEND : S_TXW;
                        end
                    end
                    S_TXB:
                    begin
                        if (tx_free)
                        begin
                            o_valid_q <= 1'b1;
                            o_ctrl_q <= 1'b0;
                            o_data_q <= pbyte_q; // see R8
                            cnt_q <= cnt_inc;
                            per_we_q <= 1'b0;
                            per_req_q <= (cnt_inc != size_q);
                            state_q <= (cnt_inc == size_q) ? S_TXEND : S_PRD;
                        end
                    end
                    S_TXEND:
                    begin
                        if (tx_free)
                        begin
                            o_valid_q <= 1'b1;
                            o_ctrl_q <= 1'b1;
                            o_data_q <= `CFGM_TOK_END; // see R5
                            state_q <= S_IDLE;
                        end
                    end
                    S_TXFAIL:
                    begin
                        if (tx_free)
                        begin
                            o_valid_q <= 1'b1;
                            o_ctrl_q <= 1'b1;
                            o_data_q <= `CFGM_TOK_FAIL; // see R10
                            state_q <= S_TXEND;
                        end
                    end
                    default:
                    begin
                        state_q <= S_IDLE;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------------
    // Output wiring
    // ------------------------------------------------------------------------
    assign out_valid_o = o_valid_q;
    assign out_ctrl_o = o_ctrl_q;
    assign out_data_o = o_data_q;
    assign out_dest_o = resp_val; // see R9
    assign cfg_req_o = cfg_req_q;
    assign cfg_we_o = cfg_we_q;
    assign cfg_addr_o = reg_val;
    assign cfg_wdata_o = word_val;
    assign per_req_o = per_req_q;
    assign per_we_o = per_we_q;
    assign per_id_o = pid_q;
    assign per_addr_o = preg_q;
    assign per_wdata_o = per_wdata_q;

endmodule

// >>> dv/cfgm_msg_monitor.sv
// Checker for the config message handler
`timescale 1ns/1ps
`include "cfgm_consts.vh"
module cfgm_msg_monitor (
    input wire clk_i,
    input wire resetn_i,
    input wire tok_ready_o,
    input wire out_valid_o,
    input wire out_ctrl_o,
    input wire [7:0] out_data_o,
    input wire [23:0] out_dest_o,
    input wire out_ready_i,
    input wire [31:0] req_dest_i,
    input wire cfg_req_o,
    input wire cfg_ack_i,
    input wire cfg_ok_i,
    input wire per_req_o,
    input wire [7:0] per_id_o
);
    // -----
    // Reply tokens
    // -----
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    a_ok_reply: assert property (cfg_ack_i && cfg_ok_i |-> ##[1:2]
        out_valid_o && out_ctrl_o && out_data_o == `CFGM_TOK_OK) else $error("no ok");
    a_fail_reply: assert property (cfg_ack_i && !cfg_ok_i |-> ##[1:2]
        out_valid_o && out_ctrl_o && out_data_o == `CFGM_TOK_FAIL) else $error("no fail");
    a_fail_closed: assert property (out_valid_o && out_ready_i && out_ctrl_o
        && out_data_o == `CFGM_TOK_FAIL |=> out_valid_o && out_ctrl_o
        && out_data_o == `CFGM_TOK_END) else $error("fail not closed");
    a_reply_held: assert property (out_valid_o && !out_ready_i |=> out_valid_o
        && $stable({out_ctrl_o, out_data_o, out_dest_o})) else $error("reply dropped");
    // -----
    // Register accesses
    // -----
    a_busy_refuse: assert property (cfg_req_o |-> !tok_ready_o)
        else $error("token taken in access");
    a_req_pulse: assert property (cfg_req_o |=> !cfg_req_o)
        else $error("access repeated");
    a_node_target: assert property (cfg_req_o |-> req_dest_i[15:0] == `CFGM_NODE_LOW16)
        else $error("bad node target");
    a_per_target: assert property (per_req_o |-> per_id_o == req_dest_i[15:8]
        && req_dest_i[7:0] == `CFGM_PER_LOW8) else $error("bad periph target");
    c_nak: cover property (cfg_ack_i && !cfg_ok_i);
    c_per: cover property (per_req_o);
    c_stall: cover property (out_valid_o && !out_ready_i);
endmodule

bind cfgm_msg cfgm_msg_monitor u_mon (.*);

// >>> dv/cfgm_back_model.sv
// Behavioural register store answering one access at a time
`timescale 1ns/1ps
module cfgm_back_model #(
    parameter int W = 32 // Register width
) (
    input wire clk_i,
    input wire resetn_i,
    input wire nak_i,
    input wire slow_i,
    input wire req_i,
    input wire we_i,
    input wire [7:0] addr_i,
    input wire [W-1:0] wdata_i,
    output logic ack_o,
    output logic ok_o,
    output wire [W-1:0] rdata_o
);
    logic [W-1:0] mem [256]; // Contents, cleared at start
    logic [W-1:0] d_q;
    logic [7:0] a_q;
    logic [1:0] wait_q; // Extra cycles when slow
    logic busy_q, we_q;
    initial foreach (mem[i]) mem[i] = '0;
    // Answer after one or four cycles; refused writes leave contents alone
    always @(posedge clk_i or negedge resetn_i)
        if (!resetn_i)
            {busy_q, ack_o, ok_o} <= 3'h0;
        else
        begin
            ack_o <= 1'b0;
            if (req_i)
                {busy_q, wait_q, we_q, a_q, d_q} <= {1'b1, {2{slow_i}}, we_i, addr_i, wdata_i};
            else if (busy_q && wait_q != 2'h0)
                wait_q <= wait_q - 2'h1;
            else if (busy_q)
            begin
                {busy_q, ack_o, ok_o} <= {2'h1, !nak_i};
                if (we_q && !nak_i)
                    mem[a_q] <= d_q;
            end
        end
    // Read data means something only with the answer
    assign rdata_o = ack_o ? mem[a_q] : ~mem[a_q];
endmodule

// >>> dv/testbench.sv
// Random and corner-case bench for the config message handler
`timescale 1ns/1ps
`include "cfgm_consts.vh"
module testbench;
    logic clk_i = 1'b0, resetn_i = 1'b0, tok_valid_i = 1'b0, tok_ctrl_i = 1'b0;
    logic out_ready_i = 1'b0, nak = 1'b0, slow = 1'b0, dchk = 1'b0;
    logic [7:0] tok_data_i = 8'h00, preg [256];
    logic [31:0] req_dest_i = 32'h0000_0000, seed = 32'h0000_C05C, nreg [256];
    wire tok_ready_o, out_valid_o, out_ctrl_o, cfg_req_o, cfg_we_o, cfg_ack_i, cfg_ok_i;
    wire per_req_o, per_we_o, per_ack_i, per_ok_i;
    wire [7:0] out_data_o, per_id_o, per_addr_o, per_wdata_o, per_rdata_i;
    wire [15:0] cfg_addr_o;
    wire [23:0] out_dest_o;
    wire [31:0] cfg_wdata_o, cfg_rdata_i;
    logic [8:0] tx[$], exp_q[$], got_q[$]; // {control, value}
    logic [23:0] resp;
    int fails = 0, n_checks = 0, cyc = 0;
    always #10 clk_i = ~clk_i;
    cfgm_msg u_dut (.*);
    cfgm_back_model #(.W(32)) u_node (.clk_i, .resetn_i, .nak_i(nak), .slow_i(slow),
        .req_i(cfg_req_o), .we_i(cfg_we_o), .addr_i(cfg_addr_o[7:0]), .wdata_i(cfg_wdata_o),
        .ack_o(cfg_ack_i), .ok_o(cfg_ok_i), .rdata_o(cfg_rdata_i));
    cfgm_back_model #(.W(8)) u_per (.clk_i, .resetn_i, .nak_i(nak), .slow_i(slow),
        .req_i(per_req_o), .we_i(per_we_o), .addr_i(per_addr_o), .wdata_i(per_wdata_o),
        .ack_o(per_ack_i), .ok_o(per_ok_i), .rdata_o(per_rdata_i));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Queue n bytes of v, most significant first
    function automatic void put(input logic [31:0] v, input int n, input logic c, input bit e);
        for (int j = n - 1; j >= 0; j--)
            if (e) exp_q.push_back({c, v[8*j+:8]});
            else tx.push_back({c, v[8*j+:8]});
    endfunction
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk_tok(input logic [8:0] g, input logic [8:0] e);
        n_checks++;
        if (g !== e)
        begin
            fails++;
            $display("[ERR] %0t token %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk_dest(input logic [23:0] g, input logic [23:0] e);
        n_checks++;
        if (g !== e)
        begin
            fails++;
            $display("[ERR] %0t reply sent to %h not %h", $time, g, e);
        end
    endtask
    // Stalls come in slow runs only; a limit cuts a hang
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        out_ready_i <= !(slow && cyc % 3 == 0);
        if (cyc == 40000)
        begin
            fails++;
            finish_test();
        end
    end
    // A token is recorded in the half cycle before the edge that takes it
    always @(negedge clk_i)
        if (out_valid_o && out_ready_i)
        begin
            got_q.push_back({out_ctrl_o, out_data_o});
            if (dchk) chk_dest(out_dest_o, resp);
        end
    // Offer one token, held until the edge that takes it
    task automatic tok(input logic [8:0] t);
        tok_valid_i <= 1'b1;
        {tok_ctrl_i, tok_data_i} <= t;
        @(negedge clk_i);
        while (tok_ready_o !== 1'b1) @(negedge clk_i);
        @(posedge clk_i);
    endtask
    // Kinds: node write, node read, periph write, periph read, broken
    task automatic msg(input int k, input logic bad, input logic [1:0] ns);
        logic [31:0] w;
        logic [7:0] a, s, h;
        logic ok;
        w = rnd();
        a = 8'(rnd());
        s = 8'(rnd() % 4);
        resp = 24'(rnd());
        h = k == 0 ? `CFGM_TOK_NODE_WR : k == 1 ? `CFGM_TOK_NODE_RD : k == 2 ?
            `CFGM_TOK_PER_WR : k == 3 ? `CFGM_TOK_PER_RD : bad ? `CFGM_TOK_NODE_WR : 8'h55;
        tx = {};
        exp_q = {};
        got_q = {};
        dchk <= k < 4 && !bad;
        ok = k < 4 && !bad && !(ns[1] && (k < 2 || s != 8'h00));
        {nak, slow} <= ns;
        req_dest_i <= {16'h0001, k < 2 ? (bad ? 16'hC30D : `CFGM_NODE_LOW16)
            : {8'h07, bad ? 8'h03 : `CFGM_PER_LOW8}};
        put(h, 1, 1'b1, 0);
        put(resp, 3, 1'b0, 0);
        if (k < 4) put(a, k < 2 ? 2 : 1, 1'b0, 0);
        if (k == 2 || k == 3) put(s, 1, 1'b0, 0);
        if (k == 0) put(w, 4, 1'b0, 0);
        if (k == 2) put(w, s, 1'b0, 0);
        put(`CFGM_TOK_END, 1, 1'b1, 0);
        put(ok ? `CFGM_TOK_OK : `CFGM_TOK_FAIL, 1, 1'b1, 1);
        if (ok && k == 0) nreg[a] = w;
        if (ok && k == 1) put(nreg[a], 4, 1'b0, 1);
        for (int j = 0; ok && j < s; j++)
            if (k == 2) preg[8'(a + j)] = w[8*(s-1-j)+:8];
            else if (k == 3) exp_q.push_back({1'b0, preg[8'(a + j)]});
        put(`CFGM_TOK_END, 1, 1'b1, 1);
        foreach (tx[j]) tok(tx[j]);
        tok_valid_i <= 1'b0;
        for (int t = 0; t < 300 && got_q.size() < exp_q.size(); t++) @(posedge clk_i);
        chk_tok(9'(got_q.size()), 9'(exp_q.size()));
        foreach (exp_q[j])
            if (j < got_q.size()) chk_tok(got_q[j], exp_q[j]);
        $display("test kind %0d bad %0d done", k, bad);
    endtask
    initial
    begin
        foreach (nreg[i]) nreg[i] = 32'h0000_0000;
        foreach (preg[i]) preg[i] = 8'h00;
        repeat (12) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(negedge clk_i);
        chk_tok({out_valid_o, 7'h00, tok_ready_o}, 9'h001);
        @(posedge clk_i);
        for (int i = 0; i < 150; i++)
            msg(i < 5 ? i : rnd() % 5, i > 4 && rnd() % 6 == 0, i > 4 ? 2'(rnd()) : 2'h0);
        finish_test();
    end
endmodule
